// ### hdl/owr_host_end.sv
// Purpose: Host end of the one-wire readout link; fetches 40-bit packets.
// Assumes: Sensor end shares clk_i; line keeper holds released levels.
// Notes:   Bit period is high + settle + one low cycle; keep it under 22 us.
//
// Operation
// - Exchange begins with a low-to-high line edge
// - Mode picks which party makes the start
// - Mode field: host, sensor, alarm, reserved
// - Alarm: sensor raises line and holds it
// - Host clears alarm with 160 us low
// - After alarm, read only after 120 us
// - Host releases line while awaiting sensor edge
// - Host start: 120 us high, then low
// - Sensor announces data every 16 ms
// - Sensor start: wait 120 us before bits
// - Host-started reading is the preferred mode
// - Host pulses high; sensor pulls low for 0
// - Settle just under 22 us, never below 2
// - Low then new rise per bit, to bit 0
// - Packet: flag, 14-bit value, 25-bit configuration
// - After last bit, low over 1250 us
// - No low or bit period over 22 us
// - Whole packet within 800 us; 12.5 ms sensor-started (default settle makes the 40 bit periods alone take 844.8 us)
// - Abort after any bit: low over 1250 us
// - Read packets at a fixed equal interval
`timescale 1ns/100ps

module owr_host_end #(
  parameter int BIT_SETTLE_CYC    = owr_pkg::BIT_SETTLE_DEF_CYC,
  parameter int REFRESH_LOW_CYC   = owr_pkg::REFRESH_LOW_CYC,
  parameter int READ_INTERVAL_CYC = owr_pkg::READ_INTERVAL_CYC
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  owr_link_if.host                             link,
  input  wire logic [1:0]                      mode_i,
  input  wire logic                            start_i,
  input  wire logic                            run_i,
  input  wire logic                            abort_i,
  input  wire logic                            read_alarm_i,
  output logic [owr_pkg::PACKET_BITS-1:0]      packet_o,
  output logic                                 overrange_flag_o,
  output logic [owr_pkg::ADC_W-1:0]            adc_o,
  output logic [owr_pkg::CFG_W-1:0]            config_o,
  output logic                                 valid_o,
  output logic                                 alarm_o,
  output logic                                 busy_o
);
  import owr_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE,
    H_START_HI,
    H_WAIT_RISE,
    H_WAIT_READ,
    H_ALARM_LOW,
    H_BIT_LO,
    H_BIT_HI,
    H_SETTLE,
    H_TERM
  } owr_hst_t;

  // Settle period must stay inside the legal window
  localparam int SETTLE_CYC = (BIT_SETTLE_CYC < BIT_SETTLE_MIN_CYC) ? BIT_SETTLE_MIN_CYC :
                              (BIT_SETTLE_CYC > BIT_SETTLE_MAX_CYC - HOST_HIGH_CYC - 1) ?
                              (BIT_SETTLE_MAX_CYC - HOST_HIGH_CYC - 1) : BIT_SETTLE_CYC;

  owr_hst_t                 state_reg;
  logic [CNT_W-1:0]         cnt_reg;
  logic [CNT_W-1:0]         ivl_reg;
  logic [IDX_W-1:0]         idx_reg;
  logic [PACKET_BITS-1:0]   shift_reg;
  logic                     prev_reg;
  logic                     oe_reg;
  logic                     out_reg;
  logic                     full_reg;
  logic                     tick;
  logic                     rise;
  logic                     last_cnt;

  // ************************************************************
  // Timebase and line edges
  // ************************************************************
  assign tick     = (ivl_reg == CNT_W'(READ_INTERVAL_CYC - 1));
  assign rise     = link.line & ~prev_reg;
  assign last_cnt = (cnt_reg == CNT_W'(1));

  // Interval timer keeps host-started reads equally spaced while running
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ivl_reg <= '0;
    end else if (!run_i || tick) begin
      ivl_reg <= '0;
    end else begin
      ivl_reg <= ivl_reg + 1'b1;
    end
  end

  // Previous line level for edge detection
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= link.line;
    end
  end

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= H_IDLE;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      shift_reg <= '0;
      oe_reg    <= 1'b0;
      out_reg   <= 1'b0;
      full_reg  <= 1'b0;
      alarm_o   <= 1'b0;
    end else begin
      alarm_o <= 1'b0;
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      case (state_reg)
        H_IDLE: begin
          oe_reg   <= 1'b0;
          full_reg <= 1'b0;
          idx_reg  <= IDX_W'(PACKET_BITS - 1);
          // Host-started reading is paced here; the preferred mode
          if (mode_i == MODE_HOST_START && (start_i || tick)) begin
            oe_reg    <= 1'b1;
            out_reg   <= 1'b1;
            cnt_reg   <= CNT_W'(HOST_START_HIGH_CYC);
            state_reg <= H_START_HI;
          end else if ((mode_i == MODE_SENSOR_START || mode_i == MODE_ALARM) && (start_i || run_i)) begin
            state_reg <= H_WAIT_RISE;
          end
        end
        H_START_HI: begin
          // The high hold ends in the low that opens the exchange
          if (last_cnt) begin
            out_reg   <= 1'b0;
            state_reg <= H_BIT_LO;
          end
        end
        H_WAIT_RISE: begin
          oe_reg <= 1'b0;
          if (rise) begin
            alarm_o   <= (mode_i == MODE_ALARM);
            cnt_reg   <= CNT_W'(READ_WAIT_CYC);
            state_reg <= H_WAIT_READ;
          end else if (!run_i && !start_i) begin
            state_reg <= H_IDLE;
          end
        end
        H_WAIT_READ: begin
          // Holding off from the sensor edge before any pull low
          if (last_cnt) begin
            oe_reg  <= 1'b1;
            out_reg <= 1'b0;
            if (mode_i == MODE_ALARM) begin
              cnt_reg   <= CNT_W'(ALARM_CLEAR_CYC);
              state_reg <= H_ALARM_LOW;
            end else begin
              state_reg <= H_BIT_LO;
            end
          end
        end
        H_ALARM_LOW: begin
          // Continuous low clears the alarm; reading on is optional
          if (last_cnt) begin
            if (read_alarm_i) begin
              out_reg   <= 1'b1;
              cnt_reg   <= CNT_W'(HOST_HIGH_CYC);
              state_reg <= H_BIT_HI;
            end else begin
              cnt_reg   <= CNT_W'(REFRESH_LOW_CYC);
              state_reg <= H_TERM;
            end
          end
        end
        H_BIT_LO: begin
          // One low cycle only, far below the corrupting limit
          oe_reg  <= 1'b1;
          if (abort_i) begin
            out_reg   <= 1'b0;
            cnt_reg   <= CNT_W'(REFRESH_LOW_CYC);
            state_reg <= H_TERM;
          end else begin
            out_reg   <= 1'b1;
            cnt_reg   <= CNT_W'(HOST_HIGH_CYC);
            state_reg <= H_BIT_HI;
          end
        end
        H_BIT_HI: begin
          if (last_cnt) begin
            oe_reg    <= 1'b0;
            cnt_reg   <= CNT_W'(SETTLE_CYC);
            state_reg <= H_SETTLE;
          end
        end
        H_SETTLE: begin
          // Late sample gives the sensor's pull the most time to settle
          if (last_cnt) begin
            shift_reg <= {shift_reg[PACKET_BITS-2:0], link.line};
            oe_reg    <= 1'b1;
            out_reg   <= 1'b0;
            idx_reg   <= idx_reg - 1'b1;
            if (idx_reg == '0) begin
              full_reg  <= 1'b1;
              cnt_reg   <= CNT_W'(REFRESH_LOW_CYC);
              state_reg <= H_TERM;
            end else begin
              state_reg <= H_BIT_LO;
            end
          end
        end
        H_TERM: begin
          // Long low lets the sensor refresh before the next read
          if (last_cnt) begin
            oe_reg    <= 1'b0;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // User-side results
  // ************************************************************
  // Results update only for complete packets; aborts leave them alone
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      packet_o         <= '0;
      overrange_flag_o <= 1'b0;
      adc_o            <= '0;
      config_o         <= '0;
      valid_o          <= 1'b0;
      busy_o           <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      busy_o  <= (state_reg != H_IDLE);
      if (state_reg == H_TERM && last_cnt && full_reg) begin
        packet_o         <= shift_reg;
        overrange_flag_o <= shift_reg[OVR_POS];
        adc_o            <= shift_reg[ADC_MSB:ADC_LSB];
        config_o         <= shift_reg[CFG_MSB:CFG_LSB];
        valid_o          <= 1'b1;
      end
    end
  end

  assign link.host_oe  = oe_reg;
  assign link.host_out = out_reg;

endmodule : owr_host_end

// ### hdl/owr_link_if.sv
// Purpose: Shared one-wire line joining the host end and the sensor end.
// Assumes: Both ends run on clk_i; the line holds its last level when released.
// Notes:   Host drive wins over sensor drive; a keeper models line capacitance.
`timescale 1ns/100ps

interface owr_link_if (
  input wire logic clk_i,
  input wire logic reset_i
);
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;
  logic keep_reg;

  // Resolved level: driver first, otherwise the held charge
  always_comb begin
    line = host_oe ? host_out : (dev_oe ? dev_out : keep_reg);
  end

  // Keeper, low after reset like a discharged line
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      keep_reg <= 1'b0;
    end else begin
      keep_reg <= line;
    end
  end

  modport host (output host_out, output host_oe, input line);
  modport dev  (output dev_out, output dev_oe, input line);

endinterface : owr_link_if

// ### hdl/owr_pkg.sv
// Purpose: Shared constants for the one-wire sensor readout link.
// Assumes: 25 MHz clock on both ends of the link.
// Notes:   Times are kept in microseconds; cycle counts derive from them, except HOST_HIGH_CYC.

package owr_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ                = 25;
  localparam int HOST_START_HIGH_US     = 120;
  localparam int READ_WAIT_US           = 120;
  localparam int ALARM_CLEAR_US         = 160;
  localparam int BIT_SETTLE_MAX_US      = 22;
  localparam int BIT_SETTLE_MIN_US      = 2;
  localparam int BIT_SETTLE_DEF_US      = 21;
  localparam int REFRESH_LOW_US         = 1250;
  localparam int SENSOR_ANNOUNCE_US     = 16000;
  localparam int READ_INTERVAL_US       = 20000;
  localparam int BIT_REACT_US           = 1;

  localparam int HOST_START_HIGH_CYC    = HOST_START_HIGH_US * CLK_MHZ;
  localparam int READ_WAIT_CYC          = READ_WAIT_US * CLK_MHZ;
  localparam int ALARM_CLEAR_CYC        = ALARM_CLEAR_US * CLK_MHZ;
  localparam int BIT_SETTLE_MAX_CYC     = BIT_SETTLE_MAX_US * CLK_MHZ;
  localparam int BIT_SETTLE_MIN_CYC     = BIT_SETTLE_MIN_US * CLK_MHZ;
  localparam int BIT_SETTLE_DEF_CYC     = BIT_SETTLE_DEF_US * CLK_MHZ;
  localparam int REFRESH_LOW_CYC        = REFRESH_LOW_US * CLK_MHZ + 1;
  localparam int SENSOR_ANNOUNCE_CYC    = SENSOR_ANNOUNCE_US * CLK_MHZ;
  localparam int READ_INTERVAL_CYC      = READ_INTERVAL_US * CLK_MHZ;
  localparam int BIT_REACT_CYC          = BIT_REACT_US * CLK_MHZ;
  localparam int HOST_HIGH_CYC          = 2;
  localparam int CNT_W                  = 20;

  // ************************************************************
  // Packet layout and operating modes
  // ************************************************************
  localparam int PACKET_BITS            = 40;
  localparam int OVR_POS                = 39;
  localparam int ADC_MSB                = 38;
  localparam int ADC_LSB                = 25;
  localparam int CFG_MSB                = 24;
  localparam int CFG_LSB                = 0;
  localparam int ADC_W                  = ADC_MSB - ADC_LSB + 1;
  localparam int CFG_W                  = CFG_MSB - CFG_LSB + 1;
  localparam int IDX_W                  = 6;

  localparam logic [1:0] MODE_HOST_START   = 2'h0;
  localparam logic [1:0] MODE_SENSOR_START = 2'h1;
  localparam logic [1:0] MODE_ALARM        = 2'h2;
  localparam logic [1:0] MODE_RESERVED     = 2'h3;

endpackage : owr_pkg

// ### hdl/owr_sensor_end.sv
// Purpose: Sensor end of the one-wire readout link; serves 40-bit packets.
// Assumes: Line level sampled on clk_i; host keeps its own timing.
// Notes:   Sensor drives only one-cycle pulses and relies on the line keeper.
`timescale 1ns/100ps

module owr_sensor_end #(
  parameter int REFRESH_LOW_CYC     = owr_pkg::REFRESH_LOW_CYC,
  parameter int SENSOR_ANNOUNCE_CYC = owr_pkg::SENSOR_ANNOUNCE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  owr_link_if.dev                        link,
  input  wire logic [1:0]                mode_i,
  input  wire logic                      motion_i,
  input  wire logic                      overrange_flag_i,
  input  wire logic [owr_pkg::ADC_W-1:0] adc_i,
  input  wire logic [owr_pkg::CFG_W-1:0] config_i,
  output logic                           alarm_reset_o,
  output logic                           refresh_o,
  output logic                           reading_o
);
  import owr_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_WAIT_LOW, S_ALARM, S_BITS, S_DRAIN} owr_sen_t;

  owr_sen_t                 state_reg;
  logic                     prev_reg;
  logic [CNT_W-1:0]         hi_cnt_reg;
  logic [CNT_W-1:0]         lo_cnt_reg;
  logic [CNT_W-1:0]         ann_cnt_reg;
  logic [CNT_W-1:0]         react_reg;
  logic [IDX_W-1:0]         idx_reg;
  logic [PACKET_BITS-1:0]   pkt_reg;
  logic                     drv_oe_reg;
  logic                     drv_out_reg;
  logic                     rise;
  logic                     fall;
  logic                     ann_wrap;
  logic                     refresh_hit;

  // ************************************************************
  // Line observation
  // ************************************************************
  assign rise        = link.line & ~prev_reg;
  assign fall        = ~link.line & prev_reg;
  assign ann_wrap    = (ann_cnt_reg == CNT_W'(SENSOR_ANNOUNCE_CYC - 1));
  assign refresh_hit = (lo_cnt_reg >= CNT_W'(REFRESH_LOW_CYC)) && !link.line; // Also ends a low begun before bits

  // Run-length counters of high and low levels, saturating
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_reg   <= 1'b0;
      hi_cnt_reg <= '0;
      lo_cnt_reg <= '0;
    end else begin
      prev_reg   <= link.line;
      hi_cnt_reg <= link.line ? ((&hi_cnt_reg) ? hi_cnt_reg : hi_cnt_reg + 1'b1) : '0;
      lo_cnt_reg <= link.line ? '0 : ((&lo_cnt_reg) ? lo_cnt_reg : lo_cnt_reg + 1'b1);
    end
  end

  // Free-running announce period for sensor-started reading
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ann_cnt_reg <= '0;
    end else begin
      ann_cnt_reg <= ann_wrap ? '0 : ann_cnt_reg + 1'b1;
    end
  end

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  // Packet is live while idle and frozen for the whole read
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pkt_reg <= '0;
    end else if (state_reg == S_IDLE) begin
      pkt_reg <= {overrange_flag_i, adc_i, config_i};
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg     <= S_IDLE;
      idx_reg       <= '0;
      react_reg     <= '0;
      drv_oe_reg    <= 1'b0;
      drv_out_reg   <= 1'b0;
      alarm_reset_o <= 1'b0;
      refresh_o     <= 1'b0;
      reading_o     <= 1'b0;
    end else begin
      drv_oe_reg    <= 1'b0;
      alarm_reset_o <= 1'b0;
      refresh_o     <= 1'b0;
      reading_o     <= (state_reg == S_BITS);
      case (state_reg)
        S_IDLE: begin
          idx_reg <= IDX_W'(PACKET_BITS - 1);
          // Start source is chosen by the mode; reserved mode stays silent
          if (mode_i == MODE_HOST_START && fall && hi_cnt_reg >= CNT_W'(HOST_START_HIGH_CYC)) begin
            state_reg <= S_BITS;
          end else if (mode_i == MODE_SENSOR_START && ann_wrap) begin
            drv_oe_reg  <= 1'b1;
            drv_out_reg <= 1'b1;
            state_reg   <= S_WAIT_LOW;
          end else if (mode_i == MODE_ALARM && motion_i) begin
            drv_oe_reg  <= 1'b1;
            drv_out_reg <= 1'b1;
            state_reg   <= S_ALARM;
          end
        end
        S_WAIT_LOW: begin
          if (fall) begin
            state_reg <= S_BITS;
          end
        end
        S_ALARM: begin
          // Line stays high until the host clears it; no self release.
          // Decided on the last low cycle so the host's first bit rise is not missed.
          if (!link.line && lo_cnt_reg == CNT_W'(ALARM_CLEAR_CYC - 1)) begin
            alarm_reset_o <= 1'b1;
            state_reg     <= S_BITS;
          end
        end
        S_BITS: begin
          if (rise) begin
            react_reg <= CNT_W'(BIT_REACT_CYC);
          end else if (react_reg != '0) begin
            react_reg <= react_reg - 1'b1;
            // Pull low for a zero once the host has let go
            if (react_reg == CNT_W'(1)) begin
              drv_oe_reg  <= ~pkt_reg[idx_reg];
              drv_out_reg <= 1'b0;
              idx_reg     <= idx_reg - 1'b1;
              if (idx_reg == '0) begin
                state_reg <= S_DRAIN;
              end
            end
          end
          if (refresh_hit) begin
            refresh_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_DRAIN: begin
          if (refresh_hit) begin
            refresh_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign link.dev_oe  = drv_oe_reg;
  assign link.dev_out = drv_out_reg;

endmodule : owr_sensor_end

// ### testbench/owr_link_assertions.sv
// Purpose: Timing checks on the shared line between host end and sensor end
// Assumes: One clock domain; counters restart when the host changes drive
// Notes:   Watches interface signals only, so both ends are judged together
`timescale 1ns/100ps

module owr_link_assertions #(
  parameter int BIT_SETTLE_CYC  = owr_pkg::BIT_SETTLE_DEF_CYC,
  parameter int REFRESH_LOW_CYC = owr_pkg::REFRESH_LOW_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic line
);
  import owr_pkg::*;

  // ********
  // Drive-length counters
  // ********
  logic [CNT_W-1:0] hi_cnt_reg;
  logic [CNT_W-1:0] lo_cnt_reg;
  logic [CNT_W-1:0] rel_cnt_reg;
  logic             hi_rel_reg;
  logic             oe_prev_reg;

  // Length of the current high, low and released stretch of host drive
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hi_cnt_reg  <= '0;
      lo_cnt_reg  <= '0;
      rel_cnt_reg <= '0;
      hi_rel_reg  <= 1'b0;
      oe_prev_reg <= 1'b0;
    end else begin
      hi_cnt_reg  <= (host_oe && host_out) ? hi_cnt_reg + 1'b1 : '0;
      lo_cnt_reg  <= (host_oe && !host_out) ? lo_cnt_reg + 1'b1 : '0;
      rel_cnt_reg <= host_oe ? '0 : rel_cnt_reg + 1'b1;
      hi_rel_reg  <= host_oe ? host_out : hi_rel_reg;  // Release after high marks a bit slot
      oe_prev_reg <= host_oe;
    end
  end

  // ********
  // Assertions
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_dev_single_pulse: assert property (dev_oe |=> !dev_oe)
    else $error("sensor drive lasted more than one cycle");
  chk_no_contention: assert property (dev_oe |-> !host_oe)
    else $error("sensor drove while host was driving");
  chk_bit_high_len: assert property (!host_oe && oe_prev_reg && hi_cnt_reg != 0 |-> hi_cnt_reg == HOST_HIGH_CYC)
    else $error("bit request high pulse has wrong length");
  chk_start_high_len: assert property (host_oe && !host_out && hi_cnt_reg != 0 |-> hi_cnt_reg >= HOST_START_HIGH_CYC)
    else $error("host start high too short");
  chk_settle_len: assert property (host_oe && !oe_prev_reg && hi_rel_reg |-> rel_cnt_reg == BIT_SETTLE_CYC)
    else $error("bit settle time differs from setting");
  chk_zero_window: assert property (dev_oe && !dev_out |-> hi_rel_reg && rel_cnt_reg < BIT_SETTLE_CYC)
    else $error("zero answer outside settle window");
  chk_refresh_low_len: assert property (!host_oe && oe_prev_reg && lo_cnt_reg != 0 |-> lo_cnt_reg >= REFRESH_LOW_CYC)
    else $error("host released before refresh low ran out");
  chk_bit_low_short: assert property (host_oe && host_out && lo_cnt_reg != 0
    |-> lo_cnt_reg <= BIT_SETTLE_MAX_CYC || lo_cnt_reg >= ALARM_CLEAR_CYC)
    else $error("low between bits too long");
  chk_sensor_rise: assert property (dev_oe && dev_out |-> !$past(line) ##1 line [*2])
    else $error("sensor rise not from low or not held");

  // Main scenarios reached
  cov_zero_bit: cover property (dev_oe && !dev_out);
  cov_sensor_rise: cover property (dev_oe && dev_out);
  cov_bit_slot: cover property (host_oe && !oe_prev_reg && hi_rel_reg);

endmodule : owr_link_assertions

// ### testbench/testbench.sv
// Purpose: Self-checking bench for host and sensor ends joined by the link
// Assumes: Short counts passed as parameters keep the run brief
// Notes:   Pulse outputs are counted on the falling edge, clear of updates
`timescale 1ns/100ps

module testbench;
  import owr_pkg::*;

  localparam int SETTLE   = 50;
  localparam int REFRESH  = 200;
  localparam int ANNOUNCE = 8000;
  localparam int INTERVAL = 10000;
  localparam int BOUND    = 9000;

  logic                   clk_i;
  logic                   reset_i;
  logic [1:0]             mode_i;
  logic                   start_i;
  logic                   run_i;
  logic                   abort_i;
  logic                   read_alarm_i;
  logic                   motion_i;
  logic [PACKET_BITS-1:0] data;
  logic [PACKET_BITS-1:0] packet_o;
  logic                   overrange_flag_o;
  logic [ADC_W-1:0]       adc_o;
  logic [CFG_W-1:0]       config_o;
  logic                   valid_o;
  logic                   alarm_o;
  logic                   busy_o;
  logic                   alarm_reset_o;
  logic                   refresh_o;
  logic                   reading_o;
  int                     bad_count;
  int                     compares;
  int                     ev [4];
  time                    vt [$];

  owr_link_if u_owr_link_if (.clk_i(clk_i), .reset_i(reset_i));

  owr_sensor_end #(.REFRESH_LOW_CYC(REFRESH), .SENSOR_ANNOUNCE_CYC(ANNOUNCE)) u_owr_sensor_end (
    .clk_i(clk_i), .reset_i(reset_i), .link(u_owr_link_if.dev), .mode_i(mode_i), .motion_i(motion_i),
    .overrange_flag_i(data[OVR_POS]), .adc_i(data[ADC_MSB:ADC_LSB]), .config_i(data[CFG_MSB:CFG_LSB]),
    .alarm_reset_o(alarm_reset_o), .refresh_o(refresh_o), .reading_o(reading_o));

  owr_host_end #(.BIT_SETTLE_CYC(SETTLE), .REFRESH_LOW_CYC(REFRESH), .READ_INTERVAL_CYC(INTERVAL)) u_owr_host_end (
    .clk_i(clk_i), .reset_i(reset_i), .link(u_owr_link_if.host), .mode_i(mode_i), .start_i(start_i),
    .run_i(run_i), .abort_i(abort_i), .read_alarm_i(read_alarm_i), .packet_o(packet_o),
    .overrange_flag_o(overrange_flag_o), .adc_o(adc_o), .config_o(config_o), .valid_o(valid_o),
    .alarm_o(alarm_o), .busy_o(busy_o));

  owr_link_assertions #(.BIT_SETTLE_CYC(SETTLE), .REFRESH_LOW_CYC(REFRESH)) u_owr_link_assertions (
    .clk_i(clk_i), .reset_i(reset_i), .host_out(u_owr_link_if.host_out), .host_oe(u_owr_link_if.host_oe),
    .dev_out(u_owr_link_if.dev_out), .dev_oe(u_owr_link_if.dev_oe), .line(u_owr_link_if.line));

  // 40 ns clock
  always #20 clk_i = ~clk_i;

  // Count pulse cycles; a pulse held too long shows as an extra count
  always @(negedge clk_i) begin
    if (valid_o === 1'b1) begin
      ev[0]++;
      vt.push_back($time);
    end
    if (alarm_o === 1'b1) ev[1]++;
    if (alarm_reset_o === 1'b1) ev[2]++;
    if (refresh_o === 1'b1) ev[3]++;
  end

  // ********
  // Tasks
  // ********
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic check_val(input logic [PACKET_BITS-1:0] got, input logic [PACKET_BITS-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // Bounded wait on an event count, or on idle host when sel is 4
  task automatic wait_ev(input int sel, input int target, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      if (sel < 4 ? ev[sel] >= target : busy_o === 1'b0) break;
      step(1);
    end
    if (n == bound) begin
      check_val(n, 0);
      finish_test();
    end
  endtask : wait_ev

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
  endtask : pulse

  // One host-started read with every field checked
  task automatic read_once(input logic [PACKET_BITS-1:0] pkt);
    int v;
    int r;
    wait_ev(4, 0, 100);
    data = pkt;
    v = ev[0];
    r = ev[3];
    pulse(start_i);
    wait_ev(0, v + 1, BOUND);
    step(5);
    check_val(packet_o, pkt);
    check_val(overrange_flag_o, pkt[OVR_POS]);
    check_val(adc_o, pkt[ADC_MSB:ADC_LSB]);
    check_val(config_o, pkt[CFG_MSB:CFG_LSB]);
    check_val(ev[0] - v, 1);
    check_val(ev[3] - r, 1);
  endtask : read_once

  // ********
  // Scenarios
  // ********
  initial begin
    int v, r, a, c;
    clk_i = 1'b0;
    reset_i = 1'b1;
    mode_i = MODE_HOST_START;
    start_i = 1'b0;
    run_i = 1'b0;
    abort_i = 1'b0;
    read_alarm_i = 1'b0;
    motion_i = 1'b0;
    data = '0;
    bad_count = 0;
    compares = 0;
    step(20);
    reset_i = 1'b0;
    read_once(40'hC3A596F0E1);
    read_once(40'h3C5A690F1E);
    // Abort after about 10 of the 40 bits, then a clean read
    data = 40'hFFFFFFFFFF;
    v = ev[0];
    r = ev[3];
    pulse(start_i);
    step(HOST_START_HIGH_CYC + 10 * (SETTLE + 3));
    check_val(reading_o, 1'b1);
    abort_i = 1'b1;
    wait_ev(4, 0, REFRESH + 500);
    abort_i = 1'b0;
    step(5);
    check_val(ev[0] - v, 0);
    check_val(ev[3] - r, 1);
    read_once(40'h8000000001);
    // Reserved mode ignores requests
    mode_i = MODE_RESERVED;
    v = ev[0];
    pulse(start_i);
    step(200);
    check_val(busy_o, 1'b0);
    check_val(ev[0] - v, 0);
    // Periodic host reads at a fixed spacing
    mode_i = MODE_HOST_START;
    v = vt.size();
    run_i = 1'b1;
    wait_ev(0, ev[0] + 3, 3 * INTERVAL + BOUND);
    run_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      check_val(40'(vt[v + i + 1] - vt[v + i]), INTERVAL * 40);
    end
    // Alarm without read, then alarm followed by a read
    wait_ev(4, 0, BOUND);
    mode_i = MODE_ALARM;
    run_i = 1'b1;
    step(5);
    a = ev[1];
    c = ev[2];
    v = ev[0];
    pulse(motion_i);
    wait_ev(1, a + 1, 50);
    wait_ev(2, c + 1, BOUND);
    step(2 * REFRESH + 100);
    check_val(ev[0] - v, 0);
    check_val(ev[1] - a, 1);
    read_alarm_i = 1'b1;
    data = 40'h5A5A5A5A5A;
    pulse(motion_i);
    wait_ev(0, v + 1, 2 * BOUND);
    check_val(packet_o, 40'h5A5A5A5A5A);
    check_val(ev[2] - c, 2);
    // Sensor-started read
    run_i = 1'b0;
    step(2 * REFRESH + 100);
    mode_i = MODE_SENSOR_START;
    data = 40'h0123456789;
    v = ev[0];
    run_i = 1'b1;
    wait_ev(0, v + 1, ANNOUNCE + BOUND);
    check_val(packet_o, 40'h0123456789);
    finish_test();
  end

endmodule : testbench
